// File: msl_serial_ctrl.sv
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "msl_params.svh"

// Summary of operation
// [RULE1] setting 0: ignore DTR, answer without it
// [RULE2] setting 1: DTR drop enters command state
// [RULE3] setting 2: DTR drop hangs up, autobaud
// [RULE4] setting 3: DTR drop hangs up, resets
// [RULE5] DTR drop must last programmed minimum
// [RULE6] ignore DTR rise five seconds after disconnect
// [RULE7] drain delay 0 to 255 s, reset 0
// [RULE8] DTR drop or hang-up drains transmit buffer
// [RULE9] carrier loss drains receive buffer
// [RULE10] empty buffers or zero delay: disconnect now
// [RULE11] link loss drains receive only; may discard
// [RULE12] carrier setting 0: DCD on, DSR/CTS on
// [RULE13] carrier 1, handshake 0: DCD follows carrier
// [RULE14] handshake 1, carrier 1: DSR off-hook, CTS=DCD
// [RULE15] handshake 2: DSR and CTS follow DCD
// [RULE16] handshake 3: DSR international, CTS on
// [RULE17] handshake 4: DSR and CTS international
// [RULE18] carrier 2: DCD pulses off at disconnect
// [RULE19] international DSR: on while connection exists
// [RULE20] international CTS: DTR in command, then status
// [RULE21] hardware flow control owns CTS
// [RULE22] V.23 half duplex ignores line settings
// [RULE23] synchronise DTR, time with clock counters
module msl_serial_ctrl #(
   parameter int P_TICK_CYC = `MSL_TICK_CYC
) (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   // apb slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // serial port pins
   input  wire logic        i_dtr,
   output logic             o_dcd,
   output logic             o_dsr,
   output logic             o_cts,
   // modem core status
   input  wire logic        i_carrier,
   input  wire logic        i_off_hook,
   input  wire logic        i_connecting,
   input  wire logic        i_connected,
   input  wire logic        i_cmd_state,
   input  wire logic        i_originate,
   input  wire logic        i_ans_tone,
   input  wire logic        i_tx_empty,
   input  wire logic        i_rx_empty,
   input  wire logic        i_link_loss,
   input  wire logic        i_hw_fc_cts,
   // requests to modem core
   output logic             o_aa_ok,
   output logic             o_cmd_req,
   output logic             o_hook_req,
   output logic             o_rst_req,
   output logic             o_autobaud_req,
   output logic             o_disc,
   output logic             o_drain_tx,
   output logic             o_drain_rx
);

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [2:0] msl_dec(input logic [11:0] a);
      unique case (a)
         `MSL_OFF_CTRL:     msl_dec = 3'h0;
         `MSL_OFF_DROP_MIN: msl_dec = 3'h1;
         `MSL_OFF_DRAIN:    msl_dec = 3'h2;
         `MSL_OFF_CMD:      msl_dec = 3'h3;
         `MSL_OFF_STATUS:   msl_dec = 3'h4;
         default:           msl_dec = 3'h7;
      endcase
   endfunction

   function automatic logic [15:0] msl_sec2tick(input logic [7:0] s);
      msl_sec2tick = 16'(s * `MSL_TICKS_PER_S);
   endfunction

   msl_pkg::msl_state_t s_q;
   msl_pkg::msl_state_t s_d;
   logic                drop;
   logic                hup;
   logic                rx_ev;
   logic                disc_now;
   logic                v23_on;
   logic                dsr_itu;
   logic                cts_itu;
   logic [2:0]          idx;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      s_d              = s_q;
      s_d.cmd_req      = 1'b0;
      s_d.hook_req     = 1'b0;
      s_d.rst_req      = 1'b0;
      s_d.autobaud_req = 1'b0;
      s_d.disc         = 1'b0;
      drop             = 1'b0;
      hup              = 1'b0;
      rx_ev            = 1'b0;
      disc_now         = 1'b0;
      idx              = msl_dec(i_paddr);

      // pin synchroniser, the first stage feeds only the second
      s_d.dtr_m = i_dtr;                                   // [RULE23]
      s_d.dtr_s = s_q.dtr_m;                               // [RULE23]

      // 10 ms time base shared by all second-scale timers
      s_d.tick = (s_q.tick_cnt == `MSL_TICK_W'(P_TICK_CYC - 1));
      s_d.tick_cnt = s_d.tick ? '0 : s_q.tick_cnt + 1'b1;  // [RULE23]
      if (s_q.tick && s_q.guard != '0) begin
         s_d.guard = s_q.guard - 1'b1;
      end
      if (s_q.tick && s_q.dcd_off != '0) begin
         s_d.dcd_off = s_q.dcd_off - 1'b1;
      end

      // a rise is only accepted once the guard window has run out
      if (!s_q.dtr_s) begin
         s_d.dtr_eff = 1'b0;
      end else if (s_q.guard == '0) begin
         s_d.dtr_eff = 1'b1;                               // [RULE6]
      end

      if (s_q.dtr_eff) begin
         s_d.low_cnt   = '0;
         s_d.drop_done = 1'b0;
      end else begin
         if (s_q.tick && s_q.low_cnt != 8'hFF) begin
            s_d.low_cnt = s_q.low_cnt + 1'b1;
         end
         // tick phase runs free, so one extra tick keeps the drop at least the minimum
         if (!s_q.drop_done && (s_q.low_cnt > s_q.dtr_drop_min_time_reg
                                || s_q.dtr_drop_min_time_reg == 8'h00)) begin
            drop          = 1'b1;                          // [RULE5]
            s_d.drop_done = 1'b1;
         end
      end

      if (drop) begin
         unique case (s_q.ctrl.dtr_resp)
            2'h0: ;                                        // [RULE1]
            2'h1: s_d.cmd_req = 1'b1;                      // [RULE2]
            2'h2: begin
               s_d.hook_req     = 1'b1;                    // [RULE3]
               s_d.autobaud_req = 1'b1;
               hup              = 1'b1;                    // [RULE8]
            end
            2'h3: begin
               s_d.hook_req     = 1'b1;                    // [RULE4]
               s_d.rst_req      = 1'b1;
               s_d.autobaud_req = 1'b1;
               hup              = 1'b1;                    // [RULE8]
            end
         endcase
      end

      // ****************************************************************
      // apb slave, one wait state per access
      // ****************************************************************
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;
      if (i_psel && i_penable && !s_q.pready) begin
         s_d.pready  = 1'b1;
         s_d.pslverr = (idx == 3'h7);
         unique case (idx)
            3'h0:    s_d.prdata = {23'h000000, s_q.ctrl};
            3'h1:    s_d.prdata = {24'h000000, s_q.dtr_drop_min_time_reg};
            3'h2:    s_d.prdata = {24'h000000, s_q.drain_s};
            3'h4:    s_d.prdata = {22'h000000, s_q.guard != '0,
                                   s_q.dcd_off != '0, s_q.st == msl_pkg::MSL_ST_DRAIN,
                                   s_q.drain_rx, s_q.dtr_eff, s_q.aa_ok,
                                   s_q.cts, s_q.dsr, s_q.dcd, s_q.dtr_s};
            default: s_d.prdata = 32'h00000000;
         endcase
      end
      if (i_psel && i_penable && s_q.pready && i_pwrite && !s_q.pslverr) begin
         unique case (idx)
            3'h0: s_d.ctrl = msl_pkg::msl_ctrl_t'(i_pwdata[`MSL_CTRL_W-1:0]);
            3'h1: s_d.dtr_drop_min_time_reg = i_pwdata[7:0];
            3'h2: s_d.drain_s = i_pwdata[7:0];             // [RULE7]
            3'h3: hup = hup | i_pwdata[`MSL_CMD_HANGUP_BIT]; // [RULE8]
            default: ;
         endcase
      end

      // ****************************************************************
      // disconnect sequencing
      // ****************************************************************
      s_d.carrier_p = i_carrier;
      rx_ev = (s_q.carrier_p && !i_carrier && i_connected)   // [RULE9]
            || i_link_loss;                                // [RULE11]
      unique case (s_q.st)
         msl_pkg::MSL_ST_IDLE: begin
            if (hup) begin
               if (s_q.drain_s == '0 || i_tx_empty || i_cmd_state) begin
                  disc_now = 1'b1;                         // [RULE10]
               end else begin
                  s_d.st       = msl_pkg::MSL_ST_DRAIN;    // [RULE8]
                  s_d.drain_rx = 1'b0;
                  s_d.drain    = msl_sec2tick(s_q.drain_s);
               end
            end else if (rx_ev) begin
               if (s_q.drain_s == '0 || i_rx_empty || i_cmd_state) begin
                  disc_now = 1'b1;                         // [RULE10]
               end else begin
                  s_d.st       = msl_pkg::MSL_ST_DRAIN;    // [RULE9]
                  s_d.drain_rx = 1'b1;
                  s_d.drain    = msl_sec2tick(s_q.drain_s);
               end
            end
         end
         msl_pkg::MSL_ST_DRAIN: begin
            // leftover data is dropped when the delay expires
            if ((s_q.drain_rx ? i_rx_empty : i_tx_empty) || s_q.drain == '0) begin
               disc_now = 1'b1;                            // [RULE11]
            end else if (s_q.tick) begin
               s_d.drain = s_q.drain - 1'b1;
            end
         end
      endcase
      if (disc_now) begin
         s_d.st      = msl_pkg::MSL_ST_IDLE;
         s_d.disc    = 1'b1;
         s_d.guard   = 16'(`MSL_GUARD_TICKS);              // [RULE6]
         s_d.dcd_off = 16'(`MSL_DCD_OFF_TICKS);            // [RULE18]
      end
      s_d.drain_tx_o = (s_d.st == msl_pkg::MSL_ST_DRAIN) && !s_d.drain_rx;
      s_d.drain_rx_o = (s_d.st == msl_pkg::MSL_ST_DRAIN) && s_d.drain_rx;

      // ****************************************************************
      // serial control lines
      // ****************************************************************
      s_d.aa_ok = (s_q.ctrl.dtr_resp < 2'h2) || s_q.dtr_eff; // [RULE1]
      dsr_itu = i_connecting || i_connected;               // [RULE19]
      if (i_cmd_state) begin
         cts_itu = s_q.dtr_eff;                            // [RULE20]
      end else if (i_connected) begin
         cts_itu = i_carrier;                              // [RULE20]
      end else if (i_connecting) begin
         cts_itu = i_originate ? !i_ans_tone : !i_off_hook;  // [RULE20]
      end else begin
         cts_itu = 1'b0;
      end

      unique case (s_q.ctrl.cd_sel)
         2'h0:    s_d.dcd = 1'b1;                          // [RULE12]
         2'h1:    s_d.dcd = i_carrier;                     // [RULE13]
         2'h2:    s_d.dcd = (s_q.dcd_off == '0);           // [RULE18]
         default: s_d.dcd = 1'b1;
      endcase
      unique case (s_q.ctrl.hs_sel)
         3'h1: begin
            if (s_q.ctrl.cd_sel == 2'h1) begin
               s_d.dsr = i_off_hook;                       // [RULE14]
            end else begin
               s_d.dsr = s_d.dcd;                          // [RULE18]
            end
            s_d.cts = s_d.dcd;                             // [RULE14]
         end
         3'h2: begin
            s_d.dsr = s_d.dcd;                             // [RULE15]
            s_d.cts = s_d.dcd;
         end
         3'h3: begin
            s_d.dsr = dsr_itu;                             // [RULE16]
            s_d.cts = 1'b1;
         end
         3'h4: begin
            s_d.dsr = dsr_itu;                             // [RULE17]
            s_d.cts = cts_itu;
         end
         default: begin
            s_d.dsr = 1'b1;                                // [RULE12]
            s_d.cts = 1'b1;                                // [RULE12]
         end
      endcase
      v23_on = s_q.ctrl.half_duplex_v23_setting && i_connected;
      if (v23_on) begin
         s_d.dcd = i_carrier;                              // [RULE22]
         s_d.dsr = 1'b1;
         s_d.cts = 1'b1;
      end
      if (s_q.ctrl.hw_fc_en) begin
         s_d.cts = i_hw_fc_cts;                            // [RULE21]
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q                       <= '0;
         s_q.drop_done             <= 1'b1;
         s_q.ctrl                  <= `MSL_RST_CTRL;
         s_q.dtr_drop_min_time_reg <= `MSL_RST_DROP_MIN;   // [RULE5]
         s_q.drain_s               <= `MSL_RST_DRAIN;      // [RULE7]
         s_q.dcd                   <= 1'b1;
         s_q.dsr                   <= 1'b1;
         s_q.cts                   <= 1'b1;
         s_q.aa_ok                 <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_prdata       = s_q.prdata;
   assign o_pready       = s_q.pready;
   assign o_pslverr      = s_q.pslverr;
   assign o_dcd          = s_q.dcd;
   assign o_dsr          = s_q.dsr;
   assign o_cts          = s_q.cts;
   assign o_aa_ok        = s_q.aa_ok;
   assign o_cmd_req      = s_q.cmd_req;
   assign o_hook_req     = s_q.hook_req;
   assign o_rst_req      = s_q.rst_req;
   assign o_autobaud_req = s_q.autobaud_req;
   assign o_disc         = s_q.disc;
   assign o_drain_tx     = s_q.drain_tx_o;
   assign o_drain_rx     = s_q.drain_rx_o;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   AST_DTR_IGNORE: assert property ( // [RULE1]
      drop && s_q.ctrl.dtr_resp == 2'h0 |=> !o_cmd_req && !o_hook_req && !o_rst_req)
      else $error("dtr drop acted on with response 0");
   AST_DTR_CMD: assert property ( // [RULE2]
      drop && s_q.ctrl.dtr_resp == 2'h1 |=> o_cmd_req && !o_hook_req)
      else $error("dtr drop did not request command state");
   AST_DTR_HOOK: assert property ( // [RULE3]
      drop && s_q.ctrl.dtr_resp == 2'h2 |=> o_hook_req && o_autobaud_req && !o_rst_req)
      else $error("dtr drop did not hang up");
   AST_DTR_RESET: assert property ( // [RULE4]
      drop && s_q.ctrl.dtr_resp == 2'h3 |=> o_hook_req && o_rst_req)
      else $error("dtr drop did not hang up and reset");
   AST_DROP_MIN: assert property ( // [RULE5]
      $fell(s_q.dtr_eff) && s_q.dtr_drop_min_time_reg != 8'h00 |-> !drop)
      else $error("dtr drop taken before minimum time");
   AST_GUARD: assert property ( // [RULE6]
      s_q.guard != '0 && !s_q.dtr_eff |=> !s_q.dtr_eff)
      else $error("dtr rise accepted inside guard window");
   AST_ZERO_DRAIN: assert property ( // [RULE10]
      hup && s_q.st == msl_pkg::MSL_ST_IDLE && s_q.drain_s == 8'h00 |=> o_disc)
      else $error("zero drain delay did not disconnect at once");
   AST_DCD_ON: assert property ( // [RULE12]
      s_q.ctrl.cd_sel == 2'h0 && !v23_on |=> o_dcd)
      else $error("dcd not held on with carrier setting 0");
   AST_HWFC: assert property ( // [RULE21]
      s_q.ctrl.hw_fc_en |=> o_cts == $past(i_hw_fc_cts))
      else $error("cts not driven by flow control");
   AST_V23_LINES: assert property ( // [RULE22]
      v23_on && !s_q.ctrl.hw_fc_en |=> o_dsr && o_cts && o_dcd == $past(i_carrier))
      else $error("v23 half duplex did not override line settings");

endmodule
`default_nettype wire

// File: msl_params.svh
`ifndef MSL_PARAMS_SVH
`define MSL_PARAMS_SVH

// ****************************************************************
// clock and time base
// ****************************************************************
`define MSL_CLK_NS          8
`define MSL_TICK_NS         10000000
`define MSL_TICK_CYC        (`MSL_TICK_NS / `MSL_CLK_NS)
`define MSL_TICK_W          21
`define MSL_TICKS_PER_S     100
`define MSL_GUARD_S         5
`define MSL_GUARD_TICKS     (`MSL_GUARD_S * `MSL_TICKS_PER_S)
`define MSL_DCD_OFF_S       2
`define MSL_DCD_OFF_TICKS   (`MSL_DCD_OFF_S * `MSL_TICKS_PER_S)

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define MSL_OFF_CTRL        12'h000
`define MSL_OFF_DROP_MIN    12'h004
`define MSL_OFF_DRAIN       12'h008
`define MSL_OFF_CMD         12'h00C
`define MSL_OFF_STATUS      12'h010

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define MSL_CTRL_W          9
`define MSL_CMD_HANGUP_BIT  0
`define MSL_RST_CTRL        9'h000
`define MSL_RST_DROP_MIN    8'h05
`define MSL_RST_DRAIN       8'h00

`endif

// File: msl_pkg.sv
`default_nettype none
package msl_pkg;

   // ****************************************************************
   // control register layout, lsb is the dtr response setting
   // ****************************************************************
   typedef struct packed {
      logic       half_duplex_v23_setting;
      logic       hw_fc_en;
      logic [2:0] hs_sel;
      logic [1:0] cd_sel;
      logic [1:0] dtr_resp;
   } msl_ctrl_t;

   typedef enum logic [0:0] {
      MSL_ST_IDLE,
      MSL_ST_DRAIN
   } msl_st_t;

   typedef struct packed {
      logic        dtr_m;
      logic        dtr_s;
      logic        dtr_eff;
      logic [20:0] tick_cnt;
      logic        tick;
      logic [7:0]  low_cnt;
      logic        drop_done;
      logic        carrier_p;
      logic [15:0] guard;
      logic [15:0] dcd_off;
      logic [15:0] drain;
      msl_st_t     st;
      logic        drain_rx;
      msl_ctrl_t   ctrl;
      logic [7:0]  dtr_drop_min_time_reg;
      logic [7:0]  drain_s;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        dcd;
      logic        dsr;
      logic        cts;
      logic        aa_ok;
      logic        cmd_req;
      logic        hook_req;
      logic        rst_req;
      logic        autobaud_req;
      logic        disc;
      logic        drain_tx_o;
      logic        drain_rx_o;
   } msl_state_t;

endpackage
`default_nettype wire

// File: msl_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// host terminal driving the dtr pin
// ****************************************************************
module msl_host_model #(
   parameter int P_HOLD_CYC = 80
) (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   // request from the bench and the pin
   input  wire logic i_dtr_req,
   output logic      o_dtr
);
   int hold;

   // a drop is never shorter than the hold, even if the bench asks
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_dtr <= 1'b1;
         hold  <= 0;
      end else if (hold > 0) begin
         hold <= hold - 1;
      end else if (!i_dtr_req && o_dtr) begin
         o_dtr <= 1'b0;
         hold  <= P_HOLD_CYC;
      end else begin
         o_dtr <= i_dtr_req;
      end
   end
endmodule
`default_nettype wire

// File: tb_modem_serial_line_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "msl_params.svh"

module tb_modem_serial_line_control;
   // ****************************************************************
   // signals
   // ****************************************************************
   localparam int TC = 10;
   localparam logic [4:0] VEC [3] = '{5'b00000, 5'b11110, 5'b01101};
   logic        clk, rst_n, psel, penable, pwrite, dtr_req, dtr, clr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, ex;
   logic        pready, pslverr, serr, dcd, dsr, cts, aa_ok;
   logic        cmd_r, hook_r, rst_r, abd_r, disc, dtx, drx;
   logic        car, oh, cn, conn, cmd_st, org, at, txe, rxe, lnk, fcts;
   int          err_total, checks_done, n;
   int          cnt [5];

   msl_host_model #(.P_HOLD_CYC(8 * TC)) u_msl_host_model (
      .i_clk(clk), .i_rst_n(rst_n), .i_dtr_req(dtr_req), .o_dtr(dtr));

   msl_serial_ctrl #(.P_TICK_CYC(TC)) u_msl_serial_ctrl (
      .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_dtr(dtr), .o_dcd(dcd),
      .o_dsr(dsr), .o_cts(cts), .i_carrier(car), .i_off_hook(oh),
      .i_connecting(cn), .i_connected(conn), .i_cmd_state(cmd_st),
      .i_originate(org), .i_ans_tone(at), .i_tx_empty(txe), .i_rx_empty(rxe),
      .i_link_loss(lnk), .i_hw_fc_cts(fcts), .o_aa_ok(aa_ok),
      .o_cmd_req(cmd_r), .o_hook_req(hook_r), .o_rst_req(rst_r),
      .o_autobaud_req(abd_r), .o_disc(disc), .o_drain_tx(dtx), .o_drain_rx(drx));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // request pulses are one cycle, so count them rather than catch them
   always @(posedge clk) begin
      if (clr) begin
         cnt = '{0, 0, 0, 0, 0};
      end else begin
         cnt[0] += cmd_r;
         cnt[1] += hook_r;
         cnt[2] += rst_r;
         cnt[3] += abd_r;
         cnt[4] += disc;
      end
   end

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd   = prdata;
      serr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         err_total++;
         summarize();
      end
   endtask

   task automatic wait_disc(input int lim);
      n = 0;
      // a pulse launched at the edge the caller returned on is only seen after it settles
      #1;
      while (disc !== 1'b1 && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (disc !== 1'b1) begin
         err_total++;
         summarize();
      end
   endtask

   task automatic settle(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   function automatic logic [31:0] exp_lines(input int c, input int h, input logic [4:0] v);
      logic dcd_e, dsr_e, cts_e, icts;
      dcd_e = (c == 1) ? v[4] : 1'b1;
      icts  = v[2] ? (v[1] ? !v[0] : !v[3]) : 1'b0;
      case (h)
         0: {dsr_e, cts_e} = 2'b11;
         1: {dsr_e, cts_e} = {((c == 1) ? v[3] : dcd_e), dcd_e};
         2: {dsr_e, cts_e} = {dcd_e, dcd_e};
         3: {dsr_e, cts_e} = {v[2], 1'b1};
         default: {dsr_e, cts_e} = {v[2], icts};
      endcase
      return {29'h0, dcd_e, dsr_e, cts_e};
   endfunction

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      {psel, penable, pwrite, paddr, pwdata, rst_n, clr} = '0;
      {car, oh, cn, conn, cmd_st, org, at, lnk, fcts} = '0;
      {dtr_req, txe, rxe} = 3'b111;
      err_total = 0;
      checks_done = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, `MSL_OFF_CTRL, 32'h0);
      chk("ctrl", 32'h0, rd);
      apb(1'b0, `MSL_OFF_DROP_MIN, 32'h0);
      chk("drop_min", 32'h5, rd);
      apb(1'b0, `MSL_OFF_DRAIN, 32'h0);
      chk("drain", 32'h0, rd);
      apb(1'b1, `MSL_OFF_DRAIN, 32'hFF);
      apb(1'b0, `MSL_OFF_DRAIN, 32'h0);
      chk("drain_max", 32'hFF, rd);
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped", 32'h1, {31'h0, serr});
      chk("lines_rst", 32'h7, {29'h0, dcd, dsr, cts});
      for (int c = 0; c < 3; c++) begin
         for (int h = 0; h < 5; h++) begin
            apb(1'b1, `MSL_OFF_CTRL, {25'h0, 3'(h), 2'(c), 2'b00});
            for (int v = 0; v < 3; v++) begin
               @(posedge clk);
               {car, oh, cn, org, at} <= VEC[v];
               settle(4);
               ex = exp_lines(c, h, VEC[v]);
               chk("dcd", {31'h0, ex[2]}, {31'h0, dcd});
               chk("dsr", {31'h0, ex[1]}, {31'h0, dsr});
               chk("cts", {31'h0, ex[0]}, {31'h0, cts});
            end
         end
      end
      apb(1'b1, `MSL_OFF_CTRL, 32'h80);
      settle(4);
      chk("fc_cts_lo", 32'h0, {31'h0, cts});
      fcts <= 1'b1;
      settle(4);
      chk("fc_cts_hi", 32'h1, {31'h0, cts});
      {car, oh, cn, org, at} <= 5'b11000;
      conn <= 1'b1;
      apb(1'b1, `MSL_OFF_CTRL, 32'h124);
      car <= 1'b0;
      settle(4);
      chk("v23_lines", 32'h3, {29'h0, dcd, dsr, cts});
      car <= 1'b1;
      settle(5200);
      for (int r = 0; r < 4; r++) begin
         apb(1'b1, `MSL_OFF_CTRL, 32'(r));
         clr <= 1'b1;
         @(posedge clk);
         clr <= 1'b0;
         dtr_req <= 1'b0;
         settle(200);
         chk("aa_low", {31'h0, (r < 2)}, {31'h0, aa_ok});
         chk("cmd_req", 32'(r == 1), 32'(cnt[0]));
         chk("hook_req", 32'(r >= 2), 32'(cnt[1]));
         chk("rst_req", 32'(r == 3), 32'(cnt[2]));
         chk("autobaud", 32'(r >= 2), 32'(cnt[3]));
         chk("disc", 32'(r >= 2), 32'(cnt[4]));
         dtr_req <= 1'b1;
         settle(100);
         chk("aa_guard", {31'h0, (r < 2)}, {31'h0, aa_ok});
         settle(5000);
         chk("aa_after", 32'h1, {31'h0, aa_ok});
      end
      apb(1'b1, `MSL_OFF_CTRL, 32'h0);
      apb(1'b1, `MSL_OFF_DRAIN, 32'h1);
      txe <= 1'b0;
      apb(1'b1, `MSL_OFF_CMD, 32'h1);
      settle(5);
      chk("drain_tx", 32'h1, {31'h0, dtx});
      wait_disc(1200);
      chk("drain_len", 32'h1, {31'h0, (n >= 980 && n <= 1010)});
      txe <= 1'b1;
      apb(1'b1, `MSL_OFF_CTRL, 32'h28);
      rxe <= 1'b0;
      car <= 1'b0;
      settle(5);
      chk("drain_rx", 32'h1, {30'h0, dtx, drx});
      rxe <= 1'b1;
      wait_disc(20);
      chk("rx_empty_disc", 32'h1, {31'h0, (n < 10)});
      settle(1000);
      chk("dcd_off", 32'h0, {29'h0, dcd, dsr, cts});
      settle(1200);
      chk("dcd_back", 32'h7, {29'h0, dcd, dsr, cts});
      {car, txe, rxe, lnk} <= 4'b1001;
      @(posedge clk);
      lnk <= 1'b0;
      settle(3);
      chk("link_loss", 32'h1, {30'h0, dtx, drx});
      {txe, rxe} <= 2'b11;
      wait_disc(20);
      apb(1'b1, `MSL_OFF_DRAIN, 32'h0);
      txe <= 1'b0;
      apb(1'b1, `MSL_OFF_CMD, 32'h1);
      wait_disc(20);
      chk("zero_delay", 32'h1, {31'h0, (n < 10)});
      apb(1'b1, `MSL_OFF_CTRL, 32'h40);
      cmd_st <= 1'b1;
      settle(4);
      chk("itu_cmd_on", 32'h3, {30'h0, dsr, cts});
      dtr_req <= 1'b0;
      settle(8);
      chk("itu_cmd_off", 32'h0, {31'h0, cts});
      cmd_st <= 1'b0;
      settle(4);
      chk("itu_conn", 32'h1, {31'h0, cts});
      summarize();
   end
endmodule
`default_nettype wire
